//--- src/cssel_regs.vh
`ifndef CSSEL_REGS_VH
`define CSSEL_REGS_VH

// ==========================================
// Register offsets (word index on addr)
`define CSSEL_ADDR_W          4
`define CSSEL_DATA_W          16
`define CSSEL_OFS_FUNC        4'h0
`define CSSEL_OFS_SEL_A       4'h1
`define CSSEL_OFS_SEL_B       4'h2
`define CSSEL_OFS_SEL_C       4'h3
`define CSSEL_OFS_SPEED1      4'h4
`define CSSEL_OFS_SPEED7      4'hA
`define CSSEL_OFS_STATUS      4'hB

// ==========================================
// Function register fields
`define CSSEL_FUNC_MODE_BIT   0
`define CSSEL_FUNC_DIR_BIT    1
`define CSSEL_FUNC_RESET      16'h0001

// ==========================================
// Selector codes
`define CSSEL_CODE_W          8
`define CSSEL_CODE_OFF        8'h00
`define CSSEL_CODE_ON         8'h01
`define CSSEL_CODE_DI_FIRST   8'h02
`define CSSEL_CODE_DI_LAST    8'h06
`define CSSEL_CODE_SUP_FIRST  8'h18
`define CSSEL_CODE_SUP_LAST   8'h1D
`define CSSEL_CODE_ANY_TAG    2'h1
`define CSSEL_SEL_A_RESET     8'h04
`define CSSEL_SEL_B_MACRO     8'h05
`define CSSEL_SEL_C_RESET     8'h00

// ==========================================
// Preset speed reset values, rpm
`define CSSEL_SPEED1_RESET    16'h012C
`define CSSEL_SPEED2_RESET    16'h0258
`define CSSEL_SPEED3_RESET    16'h0384
`define CSSEL_SPEED4_RESET    16'h04B0
`define CSSEL_SPEED5_RESET    16'h05DC
`define CSSEL_SPEED6_RESET    16'h0960
`define CSSEL_SPEED7_RESET    16'h0000

`endif

//--- src/cssel_src_mux.v
`timescale 1ns/1ps
`include "cssel_regs.vh"

// ==========================================
// One source selector
module cssel_src_mux
(
	input  wire [7:0]  code,
	input  wire [4:0]  debounced_input_word,
	input  wire [5:0]  supervision_word,
	input  wire [63:0] any_bit_word,
	output reg         src
);

	reg [7:0] di_idx;
	reg [7:0] sup_idx;

	always @*
	begin
		di_idx = code - `CSSEL_CODE_DI_FIRST;
		sup_idx = code - `CSSEL_CODE_SUP_FIRST;
		src = 1'h0;
		if (code[7:6] == `CSSEL_CODE_ANY_TAG)
			src = any_bit_word[code[5:0]];
		else if (code == `CSSEL_CODE_OFF)
			src = 1'h0;
		else if (code == `CSSEL_CODE_ON)
			src = 1'h1;
		else if (code >= `CSSEL_CODE_DI_FIRST && code <= `CSSEL_CODE_DI_LAST)
			src = debounced_input_word[di_idx[2:0]];
		else if (code >= `CSSEL_CODE_SUP_FIRST && code <= `CSSEL_CODE_SUP_LAST)
			src = supervision_word[sup_idx[2:0]];
		else
			src = 1'h0;
	end

endmodule

//--- src/cssel_top.v
// Functional notes
// - Packed mode: sources a, b, c are index bits 0, 1, 2.
// - Code 0 is low, 1 is high, 2 is debounced input bit 0.
// - Codes 3 to 6 route debounced input bits 1 to 4.
// - Codes 24 to 29 route supervision bits 0 to 5.
// - Separate mode: selector b alone activates preset speed 2.
// - Packed mode: selector b only contributes index bit 1.
// - Selector b reset value comes from the chosen control macro.
// - Mode bit one is packed, seven speeds; zero is separate, three speeds.
// - Separate mode: lowest-numbered active source wins.
// - Direction enable: speed value multiplied by +1 forward, -1 reverse.
// - Output is stored speed of active preset, or none when inactive.
`timescale 1ns/1ps
`include "cssel_regs.vh"

module cssel_top
#(
	parameter [7:0] MACRO_SEL_B = `CSSEL_SEL_B_MACRO
)
(
	input  wire        clk,
	input  wire        rst_b,
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata,
	input  wire [4:0]  debounced_input_word,
	input  wire [5:0]  supervision_word,
	input  wire [63:0] any_bit_word,
	input  wire        direction_reverse,
	output reg  [15:0] speed_out,
	output reg         speed_active,
	output reg  [2:0]  speed_index
);

	// ==========================================
	// Decoding
	function is_speed_addr;
		input [3:0] a;
		begin
			is_speed_addr = (a >= `CSSEL_OFS_SPEED1) && (a <= `CSSEL_OFS_SPEED7);
		end
	endfunction

	function [15:0] speed_reset;
		input [2:0] i;
		begin
			case (i)
				3'h0: speed_reset = `CSSEL_SPEED1_RESET;
				3'h1: speed_reset = `CSSEL_SPEED2_RESET;
				3'h2: speed_reset = `CSSEL_SPEED3_RESET;
				3'h3: speed_reset = `CSSEL_SPEED4_RESET;
				3'h4: speed_reset = `CSSEL_SPEED5_RESET;
				3'h5: speed_reset = `CSSEL_SPEED6_RESET;
				default: speed_reset = `CSSEL_SPEED7_RESET;
			endcase
		end
	endfunction

	// ==========================================
	// Configuration storage
	reg  [15:0] func_reg;
	reg  [7:0]  sel_code [0:2];
	reg  [15:0] speed_mem [0:6];
	wire [2:0]  src;
	wire [3:0]  speed_ofs;
	wire [2:0]  speed_slot;
	integer     k;

	assign speed_ofs = addr - `CSSEL_OFS_SPEED1;
	assign speed_slot = speed_ofs[2:0];

	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			func_reg <= `CSSEL_FUNC_RESET;
			sel_code[0] <= `CSSEL_SEL_A_RESET;
			sel_code[1] <= MACRO_SEL_B;
			sel_code[2] <= `CSSEL_SEL_C_RESET;
			for (k = 0; k < 7; k = k + 1)
				speed_mem[k] <= speed_reset(k[2:0]);
		end
		else if (wr)
		begin
			case (addr)
				`CSSEL_OFS_FUNC:  func_reg <= wdata & 16'h0003;
				`CSSEL_OFS_SEL_A: sel_code[0] <= wdata[7:0];
				`CSSEL_OFS_SEL_B: sel_code[1] <= wdata[7:0];
				`CSSEL_OFS_SEL_C: sel_code[2] <= wdata[7:0];
				default:
				begin
					if (is_speed_addr(addr))
						speed_mem[speed_slot] <= wdata;
				end
			endcase
		end
	end

	// ==========================================
	// Source selectors
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : gen_sel
			cssel_src_mux u_mux
			(
				.code                 (sel_code[g]),
				.debounced_input_word (debounced_input_word),
				.supervision_word     (supervision_word),
				.any_bit_word         (any_bit_word),
				.src                  (src[g])
			);
		end
	endgenerate

	// ==========================================
	// Speed selection
	reg  [2:0]  next_speed_index;
	reg         next_speed_active;
	reg  [15:0] next_speed_out;
	reg  [15:0] chosen;
	wire        packed_mode;
	wire        dir_enable;

	assign packed_mode = func_reg[`CSSEL_FUNC_MODE_BIT];
	assign dir_enable = func_reg[`CSSEL_FUNC_DIR_BIT];

	always @*
	begin
		chosen = 16'h0000;
		next_speed_index = 3'h0;
		if (packed_mode)
			next_speed_index = {src[2], src[1], src[0]};
		else if (src[0])
			next_speed_index = 3'h1;
		else if (src[1])
			next_speed_index = 3'h2;
		else if (src[2])
			next_speed_index = 3'h3;
		else
			next_speed_index = 3'h0;
		next_speed_active = (next_speed_index != 3'h0);
		if (next_speed_active)
			chosen = speed_mem[next_speed_index - 3'h1];
		// Negating -32768 wraps back to itself; software should avoid that setting
		if (!next_speed_active)
			next_speed_out = 16'h0000;
		else if (dir_enable && direction_reverse)
			next_speed_out = 16'h0000 - chosen;
		else
			next_speed_out = chosen;
	end

	// Registered once per cycle so every source is re-sampled each clock
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			speed_out <= 16'h0000;
			speed_active <= 1'b0;
			speed_index <= 3'h0;
		end
		else
		begin
			speed_out <= next_speed_out;
			speed_active <= next_speed_active;
			speed_index <= next_speed_index;
		end
	end

	// ==========================================
	// Read port
	always @(posedge clk)
	begin
		if (!rst_b)
			rdata <= 16'h0000;
		else if (rd)
		begin
			case (addr)
				`CSSEL_OFS_FUNC:   rdata <= func_reg;
				`CSSEL_OFS_SEL_A:  rdata <= {8'h00, sel_code[0]};
				`CSSEL_OFS_SEL_B:  rdata <= {8'h00, sel_code[1]};
				`CSSEL_OFS_SEL_C:  rdata <= {8'h00, sel_code[2]};
				`CSSEL_OFS_STATUS: rdata <= {8'h00, src, speed_active, 1'h0, speed_index};
				default:
				begin
					if (is_speed_addr(addr))
						rdata <= speed_mem[speed_slot];
					else
						rdata <= 16'h0000;
				end
			endcase
		end
		else
			rdata <= 16'h0000;
	end

endmodule

//--- verif/cssel_chk.sv
`timescale 1ns/1ps
// ====================
// Port checks
module cssel_chk
(
	input logic		clk,
	input logic		rst_b,
	input logic [3:0]	addr,
	input logic [15:0]	wdata,
	input logic		wr,
	input logic		rd,
	input logic [15:0]	rdata,
	input logic [4:0]	debounced_input_word,
	input logic [5:0]	supervision_word,
	input logic [63:0]	any_bit_word,
	input logic		direction_reverse,
	input logic [15:0]	speed_out,
	input logic		speed_active,
	input logic [2:0]	speed_index
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Mode shadow, so separate-mode limits can be judged at the ports
	logic	mode;
	always @(posedge clk)
		if (!rst_b)
			mode <= 1'h1;
		else if (wr && addr == 4'h0)
			mode <= wdata[0];
	sequence quiet;
		!wr && !$past(wr) && $past(rst_b) && $stable({debounced_input_word, supervision_word, any_bit_word, direction_reverse});
	endsequence
	rd_idle_a: assert property (!rd |=> rdata == 16'h0000) else $error("rdata idle");
	act_idx_a: assert property (speed_active == (speed_index != 3'h0)) else $error("active");
	none_zero_a: assert property (!speed_active |-> speed_out == 16'h0000) else $error("idle speed");
	out_hold_a: assert property (quiet ##1 quiet |-> $stable({speed_out, speed_index})) else $error("hold");
	unmapped_rd_a: assert property (rd && addr > 4'hB |=> rdata == 16'h0000) else $error("unmapped");
	status_rd_a: assert property (rd && addr == 4'hB |=>
		{rdata[4], rdata[2:0]} == {$past(speed_active), $past(speed_index)}) else $error("status");
	speed_back_a: assert property (wr && addr == 4'hA ##1 rd && addr == 4'hA |=>
		rdata == $past(wdata, 2)) else $error("readback");
	sep_range_a: assert property (!mode && !$past(mode) |-> speed_index < 3'h4) else $error("range");
endmodule
bind cssel_top cssel_chk i_cssel_chk (.*);

//--- verif/cssel_partner.sv
`timescale 1ns/1ps
// ====================
// Status sources
module cssel_partner
(
	input logic		clk,
	output logic [4:0]	debounced_input_word = 5'h00,
	output logic [5:0]	supervision_word = 6'h00,
	output logic [63:0]	any_bit_word = 64'h0,
	output logic		direction_reverse = 1'h0
);
	// Words move only on a sample edge, as real status words do
	task automatic drive(logic [4:0] d, logic [5:0] s, logic [63:0] a, logic v);
		@(posedge clk);
		debounced_input_word <= d;
		supervision_word <= s;
		any_bit_word <= a;
		direction_reverse <= v;
	endtask
endmodule

//--- verif/cssel_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s %h %h", n, e, g); end end
// ====================
// Bench
module cssel_tb_top;
	logic		clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, rev, act;
	logic [3:0]	addr = 4'h0;
	logic [15:0]	wdata = 16'h0000, rdata, spd;
	logic [2:0]	idx, ix;
	logic [4:0]	di;
	logic [5:0]	sup;
	logic [63:0]	aw;
	int		mismatches = 0, cmp_count = 0, k;
	logic [15:0]	r [11] = '{16'h0001, 16'h0004, 16'h0005, 16'h0000, 16'h012C, 16'h0258, 16'h0384, 16'h04B0,
		16'h05DC, 16'h0960, 16'h0000};
	always #20 clk = ~clk;
	cssel_partner i_cssel_partner (.clk, .debounced_input_word(di), .supervision_word(sup), .any_bit_word(aw),
		.direction_reverse(rev));
	cssel_top i_cssel_top (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .debounced_input_word(di),
		.supervision_word(sup), .any_bit_word(aw), .direction_reverse(rev), .speed_out(spd),
		.speed_active(act), .speed_index(idx));
	function logic src(logic [7:0] c);
		if (c == 8'h01) return 1'h1;
		if (c >= 8'h02 && c <= 8'h06) return di[c - 8'h02];
		if (c >= 8'h18 && c <= 8'h1D) return sup[c - 8'h18];
		return c[7:6] == 2'h1 && aw[c[5:0]];
	endfunction
	task automatic bus(logic w, logic v, logic [3:0] a, logic [15:0] d);
		@(posedge clk);
		wr <= w;
		rd <= v;
		addr <= a;
		wdata <= d;
	endtask
	task automatic rc(logic [3:0] a, logic [15:0] e);
		bus(1'h0, 1'h1, a, 16'h0000);
		bus(1'h0, 1'h0, a, 16'h0000);
		@(negedge clk);
		`CHK("rdata", e, rdata)
	endtask
	task automatic close_out;
		$display("Compares %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end
	initial
	begin
		void'($urandom(32'h1539));
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		for (int i = 0; i < 11; i++)
			rc(4'(i), r[i]);
		rc(4'hC, 16'h0000);
		$display("Reset test done");
		// Random codes mix listed, unlisted and arbitrary-bit choices
		for (int n = 0; n < 50; n++)
		begin
			for (int i = 0; i < 11; i++)
			begin
				k = $urandom % 3;
				r[i] = i == 0 || i > 3 ? 16'($urandom) : 16'(k == 0 ? $urandom % 7 : k == 1 ? 24 + $urandom % 6 : $urandom % 256);
				bus(1'h1, 1'h0, 4'(i), r[i]);
			end
			rc(4'hA, r[10]);
			rc(4'h0, r[0] & 16'h0003);
			i_cssel_partner.drive(5'($urandom), 6'($urandom), {$urandom, $urandom}, 1'($urandom));
			repeat (2) @(posedge clk);
			@(negedge clk);
			ix = r[0][0] ? {src(r[3][7:0]), src(r[2][7:0]), src(r[1][7:0])} : src(r[1][7:0]) ? 3'h1 :
				src(r[2][7:0]) ? 3'h2 : src(r[3][7:0]) ? 3'h3 : 3'h0;
			`CHK("index", ix, idx)
			`CHK("active", ix != 3'h0, act)
			`CHK("speed", ix == 3'h0 ? 16'h0000 : r[0][1] && rev ? 16'h0000 - r[ix + 4'h3] : r[ix + 4'h3], spd)
			rc(4'hB, {8'h00, src(r[3][7:0]), src(r[2][7:0]), src(r[1][7:0]), ix != 3'h0, 1'h0, ix});
		end
		$display("Random test done");
		close_out();
	end
endmodule
